//--- mcs_audio_src.sv
module mcs_audio_src
  import mcs_pkg::*;
(
  input  wire logic                   ref_clk_i,
  output logic                        in_valid_o,
  output mcs_stereo_t                 in_o,
  output mcs_stereo_t                 fx_ret_o,
  output mcs_stereo_t      [NDST-1:0] hw_in_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    in_valid_o = 1'b0;
    in_o       = '0;
    fx_ret_o   = '{l: 24'sh200000, r: 24'sh200000};
    for (int k = 0; k < NDST; k++) begin
      hw_in_o[k].l = 24'(k + 1);
      hw_in_o[k].r = 24'(k + 9);
    end
  end

  // one stereo pair per pulse, then enough idle cycles for the result to land
  task automatic send(input logic [23:0] l, input logic [23:0] r);
    @(posedge ref_clk_i);
    in_valid_o <= 1'b1;
    in_o       <= '{l: l, r: r};
    @(posedge ref_clk_i);
    in_valid_o <= 1'b0;
    repeat (14) @(posedge ref_clk_i);
  endtask
endmodule

//--- mcs_channel_strip.sv
// Chosen here: the Avalon-MM register port and the address map.
module mcs_channel_strip
  import mcs_pkg::*;
#(
  parameter int RMS_SHIFT = RMS_SH
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   resetn_i,
  input  wire logic [7:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  input  wire logic                   in_valid_i,
  input  wire mcs_stereo_t            in_i,
  input  wire mcs_stereo_t            fx_ret_i,
  input  wire mcs_stereo_t [NDST-1:0] hw_in_i,
  output mcs_stereo_t      [NDST-1:0] dst_o,
  output mcs_stereo_t      [NDST-1:0] rec_o,
  output mcs_stereo_t                 effects_send_level_o,
  output mcs_stereo_t                 mon_main_o,
  output mcs_stereo_t                 mon_phones_o,
  output logic                        out_valid_o,
  output logic                        overload_indicator_o
);
  mcs_state_t           state_r;
  logic [3:0]           cnt_r;
  logic [6:0]           ctrl_r;
  logic signed [15:0]   width_r;
  logic [15:0]          pan_r;
  logic [15:0]          fxs_r;
  logic [20:0]          ocfg_r;
  logic [15:0]          gain_r [NDST];
  logic [15:0]          fxr_r  [NDST];
  logic signed [CW-1:0] coef_r [NSEC*NCF];
  logic signed [IW-1:0] x1_r [2*NSEC];
  logic signed [IW-1:0] x2_r [2*NSEC];
  logic signed [IW-1:0] y1_r [2*NSEC];
  logic signed [IW-1:0] y2_r [2*NSEC];
  logic signed [IW-1:0] cur_l_r;
  logic signed [IW-1:0] cur_r_r;
  logic signed [IW-1:0] st_l_r;
  logic signed [IW-1:0] st_r_r;
  logic [SW-1:0]        peak_r;
  logic [31:0]          rms_r;

  function automatic logic signed [IW-1:0] sat_iw(input logic signed [47:0] v);
    if (v > IMAX) return IMAX[IW-1:0];
    if (v < IMIN) return IMIN[IW-1:0];
    return v[IW-1:0];
  endfunction

  function automatic logic signed [SW-1:0] sat_sw(input logic signed [IW-1:0] v);
    if (v > FS_MAX) return FS_MAX[SW-1:0];
    if (v < FS_MIN) return FS_MIN[SW-1:0];
    return v[SW-1:0];
  endfunction

  function automatic logic signed [IW-1:0] gmul(input logic signed [IW-1:0] x,
                                                input logic [15:0] g);
    return sat_iw((48'(x) * 48'($signed({1'b0, g}))) >>> GQ);
  endfunction

  function automatic logic signed [IW-1:0] add2(input logic signed [IW-1:0] a,
                                                input logic signed [IW-1:0] b);
    return sat_iw(48'(a) + 48'(b));
  endfunction

  function automatic logic [SW-1:0] mag(input logic signed [SW-1:0] s);
    return s[SW-1] ? SW'(-s) : s;
  endfunction

  // gain = a*x - b*x^2, which lands on 0.7071 at the centre
  function automatic logic [15:0] pgain(input logic [15:0] x);
    logic [31:0] sq;
    logic [31:0] t;
    sq = (32'(x) * 32'(x)) >> GQ;
    t  = 32'(PAN_A) * 32'(x) - 32'(PAN_B) * sq;
    return t[GQ+15:GQ];
  endfunction

  // bus slave: waitrequest drops for exactly one cycle per request
  wire        req_w   = avs_read_i | avs_write_i;
  wire        wr_go   = avs_write_i & ~avs_waitrequest_o;
  wire        rd_go   = avs_read_i & ~avs_waitrequest_o;
  wire [7:0]  ad      = avs_address_i;
  wire [31:0] wd      = avs_writedata_i;
  wire        h_ctrl  = ad == A_CTRL;
  wire        h_width = ad == A_WIDTH;
  wire        h_pan   = ad == A_PAN;
  wire        h_fxs   = ad == A_FXS;
  wire        h_trim  = ad == A_TRIM;
  wire        h_stat  = ad == A_STAT;
  wire        h_peak  = ad == A_PEAK;
  wire        h_ocfg  = ad == A_OCFG;
  wire        h_coef  = ad >= A_COEF && ad < A_COEF + 8'(4 * NSEC * NCF);
  wire [4:0]  cidx    = 5'((ad - A_COEF) >> 2);
  wire [NDST-1:0] nt_w   = ocfg_r[F_NTRIM +: NDST];
  wire [NDST-1:0] loop_w = ocfg_r[F_LOOP +: NDST];
  wire [2:0]      cue_w  = ocfg_r[F_CUE +: 3];
  wire            trim_go = wr_go & h_trim & ctrl_r[B_TRIM];
  wire [NDST-1:0] h_gain;
  wire [NDST-1:0] h_fxr;
  wire [NDST-1:0] act_w;
  wire [NDST-1:0] clamp_w;
  logic [15:0]    tg_w [NDST];
  logic [15:0]    maxg_w;
  logic [31:0]    rd_w;

  always_comb begin
    maxg_w = '0;
    for (int k = 0; k < NDST; k++) begin
      if (gain_r[k] > maxg_w) maxg_w = gain_r[k];
    end
  end

  wire signed [17:0] dlt_w = 18'(wd[15:0]) - 18'(maxg_w);

  genvar k;
  generate
    for (k = 0; k < NDST; k++) begin : g_dst
      wire signed [17:0] ts = 18'(gain_r[k]) + dlt_w;
      assign h_gain[k]  = ad == A_GAIN + 8'(4 * k);
      assign h_fxr[k]   = ad == A_FXR + 8'(4 * k);
      assign act_w[k]   = gain_r[k] != '0;
      assign clamp_w[k] = ts < 0 || ts > 18'(G_MAX);
      assign tg_w[k]    = ts < 0 ? '0 : (ts > 18'(G_MAX) ? G_MAX : ts[15:0]);
    end
  endgenerate

  always_comb begin
    rd_w = '0;
    if (h_ctrl) rd_w = 32'(ctrl_r);
    else if (h_width) rd_w = 32'(width_r);
    else if (h_pan) rd_w = 32'(pan_r);
    else if (h_fxs) rd_w = 32'(fxs_r);
    else if (h_trim) rd_w = 32'(maxg_w);
    else if (h_stat) rd_w = 32'(act_w) | (32'(overload_indicator_o) << F_OVER);
    else if (h_peak) rd_w = 32'(peak_r);
    else if (ad == A_RMS) rd_w = rms_r;
    else if (h_ocfg) rd_w = 32'(ocfg_r);
    else if (h_coef) rd_w = 32'(coef_r[cidx]);
    else begin
      for (int j = 0; j < NDST; j++) begin
        if (h_gain[j]) rd_w = 32'(gain_r[j]);
        if (h_fxr[j]) rd_w = 32'(fxr_r[j]);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
    end else begin
      avs_waitrequest_o <= ~(req_w & avs_waitrequest_o);
      if (avs_read_i & avs_waitrequest_o) avs_readdata_o <= rd_w;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_r  <= '0;
      width_r <= $signed(UNITY);
      pan_r   <= PAN_C;
      fxs_r   <= '0;
      ocfg_r  <= 21'(CUE_NONE) << F_CUE;
    end else if (wr_go) begin
      if (h_ctrl) ctrl_r <= wd[6:0];
      if (h_width) width_r <= wd[15:0];
      if (h_pan) pan_r <= wd[15:0] > UNITY ? UNITY : wd[15:0];
      if (h_fxs) fxs_r <= wd[15:0];
      if (h_ocfg) ocfg_r <= wd[20:0];
    end
  end

  // one gain per destination, no channel fader; trim moves the active ones not masked by the ocfg_r no-trim bits
  always_ff @(posedge ref_clk_i) begin
    for (int j = 0; j < NDST; j++) begin
      if (!resetn_i) begin
        gain_r[j] <= '0;
        fxr_r[j]  <= '0;
      end else if (wr_go & h_gain[j]) begin
        gain_r[j] <= wd[15:0];
      end else if (trim_go & act_w[j] & ~nt_w[j]) begin
        gain_r[j] <= tg_w[j];
      end
      if (resetn_i && wr_go && h_fxr[j]) fxr_r[j] <= wd[15:0];
    end
  end

  // biquad coefficients are five raw terms per section: b0, b1, b2, a1, a2
  always_ff @(posedge ref_clk_i) begin
    for (int j = 0; j < NSEC * NCF; j++) begin
      if (!resetn_i) coef_r[j] <= (j % NCF == 0) ? COEF_ONE : '0;
      else if (wr_go && h_coef && cidx == 5'(j)) coef_r[j] <= wd[CW-1:0];
    end
  end

  // filter engine: one section of one side per cycle
  wire [2:0]            sec_w = cnt_r[3:1];
  wire                  sen_w = (sec_w < 3'(NEQ)) ? ctrl_r[B_EQ] : ctrl_r[B_LC];
  wire signed [IW-1:0]  xin_w = cnt_r[0] ? cur_r_r : cur_l_r;
  logic signed [CW-1:0] cf_w [NCF];
  logic signed [47:0]   acc_w;
  logic signed [47:0]   ysh_w;
  logic signed [IW-1:0] y_w;
  wire                  fsat_w = ysh_w != 48'(y_w);

  generate
    for (k = 0; k < NCF; k++) begin : g_cf
      assign cf_w[k] = coef_r[int'(sec_w) * NCF + k];
    end
  endgenerate

  always_comb begin
    acc_w = 48'(cf_w[0]) * 48'(xin_w)
          + 48'(cf_w[1]) * 48'(x1_r[cnt_r])
          + 48'(cf_w[2]) * 48'(x2_r[cnt_r])
          - 48'(cf_w[3]) * 48'(y1_r[cnt_r])
          - 48'(cf_w[4]) * 48'(y2_r[cnt_r]);
    ysh_w = acc_w >>> CQ;
    y_w   = sat_iw(ysh_w);
  end

  // stereo image stage: width blend, mid/side, polarity
  wire [15:0] wa_w = 16'((17'sh04000 + 17'(width_r)) >>> 1);
  wire [15:0] wb_w = 16'((17'sh04000 - 17'(width_r)) >>> 1);
  wire signed [IW-1:0] wl_w = add2(gmul(cur_l_r, wa_w), gmul(cur_r_r, wb_w));
  wire signed [IW-1:0] wr_w = add2(gmul(cur_r_r, wa_w), gmul(cur_l_r, wb_w));
  wire signed [IW:0]   ms_m = ((IW+1)'(wl_w) + (IW+1)'(wr_w)) >>> 1;
  wire signed [IW:0]   ms_s = ((IW+1)'(wl_w) - (IW+1)'(wr_w)) >>> 1;
  wire signed [IW-1:0] ml_w = ctrl_r[B_MS] ? ms_m[IW-1:0] : wl_w;
  wire signed [IW-1:0] mr_w = ctrl_r[B_MS] ? ms_s[IW-1:0] : wr_w;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      cur_l_r <= '0;
      cur_r_r <= '0;
      st_l_r  <= '0;
      st_r_r  <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= '0;
          if (in_valid_i) begin
            cur_l_r <= ctrl_r[B_PAD] ? gmul(IW'(in_i.l), PAD_GAIN) : IW'(in_i.l);
            cur_r_r <= ctrl_r[B_PAD] ? gmul(IW'(in_i.r), PAD_GAIN) : IW'(in_i.r);
            state_r <= ST_FILT;
          end
        end
        ST_FILT: begin
          if (sen_w && cnt_r[0]) cur_r_r <= y_w;
          if (sen_w && !cnt_r[0]) cur_l_r <= y_w;
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(2 * NSEC - 1)) state_r <= ST_MIX;
        end
        ST_MIX: begin
          st_l_r  <= ctrl_r[B_POLL] ? -ml_w : ml_w;
          st_r_r  <= ctrl_r[B_POLR] ? -mr_w : mr_w;
          state_r <= ST_OUT;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    for (int j = 0; j < 2 * NSEC; j++) begin
      if (!resetn_i) begin
        x1_r[j] <= '0;
        x2_r[j] <= '0;
        y1_r[j] <= '0;
        y2_r[j] <= '0;
      end else if (state_r == ST_FILT && sen_w && cnt_r == 4'(j)) begin
        x1_r[j] <= xin_w;
        x2_r[j] <= x1_r[j];
        y1_r[j] <= y_w;
        y2_r[j] <= y1_r[j];
      end
    end
  end

  // panned, sent and returned signals
  wire [15:0]          gl_w  = pgain(UNITY - pan_r);
  wire [15:0]          gr_w  = pgain(pan_r);
  wire signed [IW-1:0] pl_w  = gmul(st_l_r, gl_w);
  wire signed [IW-1:0] pr_w  = gmul(st_r_r, gr_w);
  wire [31:0]          fxp_w = (32'(maxg_w) * 32'(fxs_r)) >> GQ;
  wire [15:0]          fxg_w = fxp_w > 32'(G_MAX) ? G_MAX : fxp_w[15:0];
  mcs_stereo_t         dnx_w [NDST];

  generate
    for (k = 0; k < NDST; k++) begin : g_mix
      assign dnx_w[k].l = sat_sw(add2(gmul(pl_w, gain_r[k]),
                                      gmul(IW'(fx_ret_i.l), fxr_r[k])));
      assign dnx_w[k].r = sat_sw(add2(gmul(pr_w, gain_r[k]),
                                      gmul(IW'(fx_ret_i.r), fxr_r[k])));
    end
  endgenerate

  wire         cue_on = cue_w != CUE_NONE && int'(cue_w) < NDST;
  mcs_stereo_t cue_s;
  assign cue_s = cue_on ? dnx_w[int'(cue_w) % NDST] : '0;
  wire         out_go = state_r == ST_OUT;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      dst_o        <= '0;
      rec_o        <= '0;
      effects_send_level_o    <= '0;
      mon_main_o   <= '0;
      mon_phones_o <= '0;
      out_valid_o  <= 1'b0;
    end else begin
      out_valid_o <= out_go;
      for (int j = 0; j < NDST; j++) begin
        if (out_go) dst_o[j] <= dnx_w[j];
        rec_o[j] <= loop_w[j] ? (out_go ? dnx_w[j] : dst_o[j]) : hw_in_i[j];
      end
      if (out_go) begin
        effects_send_level_o.l  <= sat_sw(gmul(pl_w, fxg_w));
        effects_send_level_o.r  <= sat_sw(gmul(pr_w, fxg_w));
        mon_main_o   <= ocfg_r[F_CPH] ? '0 : cue_s;
        mon_phones_o <= ocfg_r[F_CPH] ? cue_s : '0;
      end
    end
  end

  // metering is pre-fader and post-filter
  wire [SW-1:0] al_w  = mag(sat_sw(st_l_r));
  wire [SW-1:0] ar_w  = mag(sat_sw(st_r_r));
  wire [SW-1:0] am_w  = al_w > ar_w ? al_w : ar_w;
  wire [47:0]   sq_w  = 48'(am_w) * 48'(am_w);
  wire signed [33:0] rd_m = 34'(sq_w[47:16]) - 34'(rms_r);
  wire          fs_ov = st_l_r > FS_MAX || st_l_r < FS_MIN || st_r_r > FS_MAX || st_r_r < FS_MIN;
  wire          ov_set = (state_r == ST_FILT && sen_w && fsat_w) || (out_go && fs_ov);
  wire          ov_clr = wr_go & h_stat & wd[F_OVER];

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      peak_r               <= '0;
      rms_r                <= '0;
      overload_indicator_o <= 1'b0;
    end else begin
      if (out_go) begin
        peak_r <= (am_w > peak_r || (rd_go & h_peak)) ? am_w : peak_r;
        rms_r  <= 32'($signed({2'b00, rms_r}) + (rd_m >>> RMS_SHIFT));
      end else if (rd_go & h_peak) begin
        peak_r <= '0;
      end
      // a new overload wins over a clear in the same cycle
      overload_indicator_o <= ov_set | (overload_indicator_o & ~ov_clr);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_pan_centre:
    assert property (pan_r == PAN_C |-> gl_w == PAN_M3DB && gr_w == PAN_M3DB)
      else $error("centre pan is not minus three decibels");
  a_peak_attack:
    assert property (out_go && !(rd_go && h_peak) |=> peak_r >= $past(am_w))
      else $error("peak missed a single sample");
  a_mute_route:
    assert property (out_go && gain_r[0] == '0 && fxr_r[0] == '0 |=> dst_o[0] == '0)
      else $error("zero gain routing passed audio");
  a_trim_gang:
    assert property (trim_go && act_w[0] && act_w[1] && nt_w[1:0] == 2'b00
                     && clamp_w[1:0] == 2'b00
                     |=> gain_r[0] - gain_r[1] == $past(gain_r[0] - gain_r[1]))
      else $error("trim broke the spacing of routings");
  a_no_trim:
    assert property (trim_go && nt_w[2] && !(wr_go && h_gain[2]) |=> $stable(gain_r[2]))
      else $error("excluded routing moved under trim");
  a_pad_att:
    assert property (state_r == ST_IDLE && in_valid_i && ctrl_r[B_PAD]
                     |=> 2 * int'(mag(sat_sw(cur_l_r))) <= int'(mag($past(in_i.l)))
                         && 4 * int'(mag(sat_sw(cur_l_r))) >= int'(mag($past(in_i.l))))
      else $error("pad did not attenuate");
  a_ms_sum:
    assert property (state_r == ST_MIX && ctrl_r[B_MS] && !ctrl_r[B_POLL]
                     |=> st_l_r == $past(ms_m[IW-1:0]))
      else $error("mid/side left is not the sum");
  a_over_set:
    assert property (ov_set |=> overload_indicator_o)
      else $error("internal overload not flagged");
  a_loopback:
    assert property (out_go && loop_w[0] |=> rec_o[0] == dst_o[0])
      else $error("loopback record differs from mix");
  a_bus_wait:
    assert property (req_w && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("waitrequest did not drop for one cycle");

  c_trim:  cover property (trim_go && act_w[0] && act_w[1]);
  c_over:  cover property (ov_set ##1 ov_clr);
  c_loop:  cover property (out_go && loop_w[0]);
  c_cue:   cover property (out_go && cue_on && ocfg_r[F_CPH]);
endmodule

//--- mcs_channel_strip_test.sv
module mcs_channel_strip_test
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                   clk = 1'b0;
  logic                   rstn = 1'b0;
  logic                   rd = 1'b0;
  logic                   wr = 1'b0;
  logic [7:0]             adr = 8'h00;
  logic [31:0]            wd = 32'h0;
  logic [31:0]            rdd;
  logic [31:0]            q;
  logic                   wq;
  logic                   vin;
  logic                   vout;
  logic                   overload_indicator;
  mcs_stereo_t            din;
  mcs_stereo_t            fxr;
  mcs_stereo_t            fxs;
  mcs_stereo_t            mm;
  mcs_stereo_t            mp;
  mcs_stereo_t [NDST-1:0] hw;
  mcs_stereo_t [NDST-1:0] dst;
  mcs_stereo_t [NDST-1:0] rec;
  int                     err_count = 0;
  int                     checks_done = 0;

  initial begin
    forever #25 clk = ~clk;
  end

  mcs_audio_src mcs_audio_src_i (
    .ref_clk_i  (clk),
    .in_valid_o (vin),
    .in_o       (din),
    .fx_ret_o   (fxr),
    .hw_in_o    (hw)
  );

  mcs_channel_strip #(.RMS_SHIFT(2)) mcs_channel_strip_i (
    .ref_clk_i            (clk),
    .resetn_i             (rstn),
    .avs_address_i        (adr),
    .avs_read_i           (rd),
    .avs_write_i          (wr),
    .avs_writedata_i      (wd),
    .avs_readdata_o       (rdd),
    .avs_waitrequest_o    (wq),
    .in_valid_i           (vin),
    .in_i                 (din),
    .fx_ret_i             (fxr),
    .hw_in_i              (hw),
    .dst_o                (dst),
    .rec_o                (rec),
    .effects_send_level_o            (fxs),
    .mon_main_o           (mm),
    .mon_phones_o         (mp),
    .out_valid_o          (vout),
    .overload_indicator_o (overload_indicator)
  );

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // one Avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    rd  <= ~w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
    end
    r  = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(48'(r), 48'(e));
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rchk(A_WIDTH, 32'h0000_4000);
    rchk(A_PAN, 32'h0000_2000);
    rchk(A_OCFG, 32'h0007_0000);
    rchk(8'hFC, 32'h0000_0000);
    $display("test reset done");
    wreg(8'h40, 32'h0000_4000);
    wreg(8'h44, 32'h0000_2000);
    wreg(8'h48, 32'h0000_1000);
    wreg(A_OCFG, 32'h0007_0004);
    wreg(A_CTRL, 32'h0000_0040);
    wreg(A_TRIM, 32'h0000_3000);
    rchk(8'h40, 32'h0000_3000);
    rchk(8'h44, 32'h0000_1000);
    rchk(8'h48, 32'h0000_1000);
    rchk(A_TRIM, 32'h0000_3000);
    rchk(A_STAT, 32'h0000_0007);
    $display("test trim done");
    wreg(A_CTRL, 32'h0000_0000);
    wreg(8'h48, 32'h0000_0000);
    wreg(A_OCFG, 32'h0000_0100);
    mcs_audio_src_i.send(24'h7FFFFF, 24'h000000);
    rchk(A_PEAK, 32'h007F_FFFF);
    rchk(A_PEAK, 32'h0000_0000);
    rchk(A_RMS, 32'h0FFF_FFC0);
    chk(rec[0], dst[0]);
    chk(rec[1], hw[1]);
    chk(mm, dst[0]);
    chk(mp, 48'h0);
    chk(dst[2], 48'h0);
    chk(fxs, 48'h0);
    $display("test stream done");
    wreg(A_WIDTH, 32'h0000_0000);
    wreg(A_OCFG, 32'h0010_0000);
    mcs_audio_src_i.send(24'h100000, 24'h000000);
    chk(48'(dst[0].l), 48'(dst[0].r));
    chk(48'(|dst[0]), 48'h1);
    chk(mp, dst[0]);
    chk(mm, 48'h0);
    chk(rec[0], hw[0]);
    wreg(A_WIDTH, 32'h0000_4000);
    wreg(A_CTRL, 32'h0000_0008);
    mcs_audio_src_i.send(24'h100000, 24'h100000);
    chk(48'(dst[0].r), 48'h0);
    chk(48'(|dst[0].l), 48'h1);
    $display("test matrix done");
    wreg(A_CTRL, 32'h0000_0000);
    wreg(8'h44, 32'h0000_0000);
    wreg(8'h64, 32'h0000_4000);
    wreg(A_FXS, 32'h0000_4000);
    mcs_audio_src_i.send(24'h100000, 24'h100000);
    chk(48'(|dst[1]), 48'h1);
    chk(dst[3], 48'h0);
    chk(48'(|fxs), 48'h1);
    rchk(A_PEAK, 32'h0010_0000);
    $display("test effects done");
    wreg(A_CTRL, 32'h0000_0034);
    mcs_audio_src_i.send(24'h400000, 24'h400000);
    rchk(A_PEAK, 32'h0012_0A00);
    chk(48'({dst[0].l[23], dst[0].r[23]}), 48'h3);
    $display("test pad done");
    wreg(8'h40, 32'h0000_FFFF);
    wreg(A_CTRL, 32'h0000_0001);
    wreg(A_COEF, 32'h0007_FFFF);
    mcs_audio_src_i.send(24'h7FFFFF, 24'h7FFFFF);
    chk(48'(overload_indicator), 48'h1);
    rchk(A_STAT, 32'h0000_0101);
    wreg(A_STAT, 32'h0000_0100);
    rchk(A_STAT, 32'h0000_0001);
    chk(48'(overload_indicator), 48'h0);
    $display("test overload done");
    summarize();
  end
endmodule

//--- mcs_pkg.sv
package mcs_pkg;
  localparam int SW     = 24;
  localparam int IW     = 28;
  localparam int CW     = 20;
  localparam int CQ     = 18;
  localparam int GQ     = 14;
  localparam int NDST   = 6;
  localparam int NSEC   = 5;
  localparam int NEQ    = 3;
  localparam int NCF    = 5;
  localparam int RMS_SH = 10;
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_WIDTH = 8'h04;
  localparam logic [7:0] A_PAN   = 8'h08;
  localparam logic [7:0] A_FXS   = 8'h0C;
  localparam logic [7:0] A_TRIM  = 8'h10;
  localparam logic [7:0] A_STAT  = 8'h14;
  localparam logic [7:0] A_PEAK  = 8'h18;
  localparam logic [7:0] A_RMS   = 8'h1C;
  localparam logic [7:0] A_OCFG  = 8'h20;
  localparam logic [7:0] A_GAIN  = 8'h40;
  localparam logic [7:0] A_FXR   = 8'h60;
  localparam logic [7:0] A_COEF  = 8'h80;
  localparam int B_EQ    = 0;
  localparam int B_LC    = 1;
  localparam int B_PAD   = 2;
  localparam int B_MS    = 3;
  localparam int B_POLL  = 4;
  localparam int B_POLR  = 5;
  localparam int B_TRIM  = 6;
  localparam int F_NTRIM = 0;
  localparam int F_LOOP  = 8;
  localparam int F_CUE   = 16;
  localparam int F_CPH   = 20;
  localparam int F_OVER  = 8;
  localparam logic [2:0]  CUE_NONE = 3'h7;
  localparam logic [15:0] UNITY    = 16'h4000;
  localparam logic [15:0] PAN_C    = 16'h2000;
  localparam logic [15:0] PAN_A    = 16'h7505;
  localparam logic [15:0] PAN_B    = 16'h3505;
  localparam logic [15:0] PAN_M3DB = 16'h2D41;
  localparam logic [15:0] PAD_GAIN = 16'h120A;
  localparam logic [15:0] G_MAX    = 16'hFFFF;
  localparam logic signed [47:0] IMAX = 48'sh0000_07FF_FFFF;
  localparam logic signed [47:0] IMIN = -48'sh0000_0800_0000;
  localparam logic signed [IW-1:0] FS_MAX = 28'sh07FFFFF;
  localparam logic signed [IW-1:0] FS_MIN = -28'sh0800000;
  localparam logic signed [CW-1:0] COEF_ONE = 20'sh40000;
  typedef struct packed {
    logic signed [SW-1:0] l;
    logic signed [SW-1:0] r;
  } mcs_stereo_t;
  typedef enum logic [1:0] {ST_IDLE, ST_FILT, ST_MIX, ST_OUT} mcs_state_t;
endpackage
